/* common/acrc_pkg.sv */
// Constants and types shared by the converter control block.
// Assumes one master clock domain and one serial clock domain.
package acrc_pkg;
   // =====================================================
   // Widths and types
   localparam int WORD_BITS = 24;
   localparam int CMD_BITS  = 8;
   localparam int GAIN_FRAC = 22;
   typedef logic [WORD_BITS-1:0] acrc_word_t;
   typedef logic [2:0]           acrc_sel_t;
   typedef enum logic [1:0] {PS_CMD, PS_WR, PS_RD, PS_CONV} acrc_port_st_t;
   typedef enum logic [1:0] {CS_IDLE, CS_OFF, CS_GAIN} acrc_cal_st_t;

   // =====================================================
   // Reset values
   localparam acrc_word_t CFG_RST  = 24'h000040;
   localparam acrc_word_t OFF_RST  = 24'h000000;
   localparam acrc_word_t GAIN_RST = 24'h400000;

   // =====================================================
   // Configuration fields
   localparam int CFG_RS    = 7;
   localparam int CFG_RV    = 6;
   localparam int CFG_PF    = 5;
   localparam int CFG_DF    = 3;
   localparam int CFG_CC_LO = 0;
   localparam int CFG_WR_LO = 13;
   localparam acrc_word_t CFG_WMASK = 24'hfdf0b7;
   localparam acrc_word_t RS_MASK   = 24'h000080;

   // =====================================================
   // Commands and register selects
   localparam logic [7:0] CMD_NULL   = 8'h00;
   localparam logic [2:0] CMD_RW_TAG = 3'h4;
   localparam int CMD_RW_BIT = 4;
   localparam int CMD_RSB_LO = 1;
   localparam acrc_sel_t REG_OFF   = 3'h0;
   localparam acrc_sel_t REG_GAIN  = 3'h1;
   localparam acrc_sel_t REG_CFG   = 3'h2;
   localparam acrc_sel_t REG_DATA  = 3'h3;
   localparam acrc_sel_t REG_SETUP = 3'h4;
   localparam logic [1:0] SETUP_LAST = 2'h2;

   // =====================================================
   // Calibration routing to the front end
   localparam logic [1:0] RT_NORMAL = 2'h0;
   localparam logic [1:0] RT_SHORT  = 2'h1;
   localparam logic [1:0] RT_REF    = 2'h2;
   localparam logic [1:0] RT_SYSTEM = 2'h3;
   localparam acrc_word_t CAL_FS   = 24'h7fffff;
   localparam acrc_word_t GAIN_MAX = 24'hffffff;

   // =====================================================
   // Timing in master clock cycles
   localparam logic [14:0] OWR_CYC_0 = 15'h0884;
   localparam logic [14:0] OWR_CYC_1 = 15'h0444;
   localparam logic [14:0] OWR_CYC_2 = 15'h0214;
   localparam logic [14:0] OWR_CYC_3 = 15'h0184;
   localparam logic [14:0] OWR_CYC_4 = 15'h0144;
   localparam logic [9:0]  RESET_CYC = 10'h3ea;
endpackage

/* hw/acrc_sync2.sv */
// Two flip-flop level synchroniser, one bit per lane.
// Assumes inputs are glitch free register outputs of another domain.
`timescale 1ns/1ps
module acrc_sync2
  #(parameter int W = 1)
  (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
  );
   logic [W-1:0] meta;

   // =====================================================
   // First stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         q_o  <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

/* hw/acrc_correct.sv */
// Offset and gain correction of one filtered sample, saturating.
// Assumes two's complement samples and the offset/gain formats below.
`timescale 1ns/1ps
module acrc_correct
  (
   // Operands
   input  wire acrc_pkg::acrc_word_t sample_i,
   input  wire acrc_pkg::acrc_word_t offset_i,
   input  wire acrc_pkg::acrc_word_t gain_i,
   // Result
   output acrc_pkg::acrc_word_t      word_o
  );
   import acrc_pkg::*;
   logic signed [24:0] diff;
   logic signed [49:0] prod;
   logic signed [27:0] scaled;
   logic [4:0]         top;

   // =====================================================
   // Offset is MSB aligned; bit 23 is its sign, LSB is 2^-24 of span
   assign diff = 25'(signed'(sample_i)) - 25'(signed'(offset_i));
   // Gain is unsigned 2.22 fixed point
   assign prod = diff * signed'({1'b0, gain_i});
   assign scaled = prod[GAIN_FRAC +: 28];
   assign top = scaled[27:23];

   // Clamp when the top bits disagree, avoiding wraparound
   always_comb
   begin
      if (&top || ~|top)
         word_o = scaled[23:0];
      else if (top[4])
         word_o = 24'h800000;
      else
         word_o = 24'h7fffff;
   end
endmodule

/* hw/acrc_top.sv */
// Converter control: serial command port, reset cycle, calibration.
// Assumes a filter on mclk_i and a host driving sclk_i, cs_n_i, sdi_i.
// Operation
// - Eight selectable word rates scale with clock
// - Writing reset bit one runs reset cycle
// - Reset end reinitialises port, sets valid flag
// - Reset loads configuration, offset, gain defaults
// - After reset port waits in command mode
// - Valid flag clears on configuration read
// - Port flag zero: data only by read
// - Port flag one: null then 24 clocks
// - Each calibration step takes one conversion
// - Last step end clears control bits, sets done
// - Code 011 does offset then gain
// - Done clears on data/offset/gain/setup reads
// - Uncalibrated conversion uses default gain, offset
// - Offset LSB is 2^-24 of span
// - Offset bit 23 is correction sign
// - Offset bits align with data bits
// - Gain is unsigned 2.22 fixed point
// - Offset calibration result stored and applied
// - Gain calibration result stored as slope
// - Control bits choose self or system calibration
// - Commands are eight bits, MSB first
// - All-zero command clears output flag
// - All registers are 24 bits wide
// - Port flag one: output low after calibration
`timescale 1ns/1ps
module acrc_top
  #(parameter logic [14:0] OWR_CYC_5 = 15'h4424,
    parameter logic [14:0] OWR_CYC_6 = 15'h2214,
    parameter logic [14:0] OWR_CYC_7 = 15'h110c)
  (
   // Clocks and reset
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   // Serial port
   input  wire logic                 sclk_i,
   input  wire logic                 cs_n_i,
   input  wire logic                 sdi_i,
   output logic                      sdo_o,
   output logic                      sdo_oe_n_o,
   // Filter and analog front end
   input  wire acrc_pkg::acrc_word_t sample_i,
   output logic [2:0]                word_rate_o,
   output logic [1:0]                cal_route_o,
   // Corrected conversion results
   output acrc_pkg::acrc_word_t      conv_word_o,
   output logic                      conv_strobe_o
  );
   import acrc_pkg::*;

   // =====================================================
   // Declarations
   acrc_port_st_t ps;
   acrc_cal_st_t  cst;
   logic [4:0]    bitcnt;
   logic [1:0]    wcnt;
   acrc_sel_t     sel;
   acrc_word_t    sr_in;
   acrc_word_t    sh_in;
   acrc_word_t    sr_out;
   acrc_word_t    wr_word;
   acrc_sel_t     wr_sel;
   logic          shifting;
   logic          wr_tog;
   logic          rd_tog;
   logic          null_tog;
   logic          cmd_done;
   logic          word_done;
   logic          is_rw;
   logic [1:0]    s_link;
   logic          port_rst_s;
   logic          pf_s;
   logic [5:0]    s_m;
   logic          cs_s;
   logic          wr_p;
   logic          rd_p;
   logic          null_p;
   logic          wr_ev;
   logic          rd_ev;
   logic          null_ev;
   acrc_word_t    cfg;
   acrc_word_t    offset_trim;
   acrc_word_t    gain_slope;
   acrc_word_t    mir_off;
   acrc_word_t    mir_gain;
   acrc_word_t    mir_cfg;
   acrc_word_t    mir_data;
   acrc_word_t    corr_word;
   logic          rst_busy;
   logic [9:0]    rst_cnt;
   logic          rst_done;
   logic [14:0]   conv_cnt;
   logic [14:0]   owr_cyc;
   logic          conv_end;
   logic [2:0]    cc;
   logic          cal_start;
   logic          cal_done;
   logic          sdo_flag;
   logic signed [24:0] cal_diff;
   logic [45:0]   cal_quot;
   acrc_word_t    gain_calc;
   logic [1:0]    next_route;

   // Register chosen for a word; setup walks offset, gain, config
   function automatic acrc_sel_t word_sel(input acrc_sel_t s,
                                          input logic [1:0] w);
      word_sel = (s == REG_SETUP) ? {1'b0, w} : s;
   endfunction

   function automatic acrc_word_t mirror(input acrc_sel_t s);
      case (s)
         REG_OFF:  mirror = mir_off;
         REG_GAIN: mirror = mir_gain;
         REG_CFG:  mirror = mir_cfg;
         REG_DATA: mirror = mir_data;
         default:  mirror = '0;
      endcase
   endfunction

   // =====================================================
   // Serial clock domain
   acrc_sync2 #(.W(2)) u_sync_link
     (.clk_i (sclk_i),
      .rst_i (rst_i),
      .d_i   ({rst_busy, cfg[CFG_PF]}),
      .q_o   (s_link));
   assign port_rst_s = s_link[1];
   assign pf_s       = s_link[0];

   // Data enters MSB first, one bit per rising edge
   assign sh_in     = {sr_in[WORD_BITS-2:0], sdi_i};
   assign cmd_done  = (ps == PS_CMD) && (bitcnt == 5'(CMD_BITS - 1));
   assign word_done = (ps != PS_CMD) && (bitcnt == 5'(WORD_BITS - 1));
   assign is_rw     = (sh_in[7:5] == CMD_RW_TAG) && !sh_in[0];

   // Input shifter runs whenever the port is selected
   always_ff @(posedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
         sr_in <= '0;
      else if (!cs_n_i)
         sr_in <= sh_in;
   end

   // Port sequencer: command byte, then 24-bit words
   always_ff @(posedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ps       <= PS_CMD;
         bitcnt   <= 5'h0;
         wcnt     <= 2'h0;
         sel      <= REG_OFF;
         sr_out   <= '0;
         shifting <= 1'b0;
         wr_tog   <= 1'b0;
         rd_tog   <= 1'b0;
         null_tog <= 1'b0;
         wr_sel   <= REG_OFF;
         wr_word  <= '0;
      end
      else if (port_rst_s)
      begin
         ps       <= PS_CMD;
         bitcnt   <= 5'h0;
         shifting <= 1'b0;
      end
      else if (!cs_n_i)
      begin
         bitcnt <= bitcnt + 5'h1;
         sr_out <= {sr_out[WORD_BITS-2:0], 1'b0};
         case (ps)
            PS_CMD:
               if (cmd_done)
               begin
                  bitcnt <= 5'h0;
                  wcnt   <= 2'h0;
                  if (is_rw)
                  begin
                     sel <= sh_in[CMD_RSB_LO +: 3];
                     if (sh_in[CMD_RW_BIT])
                     begin
                        ps       <= PS_RD;
                        shifting <= 1'b1;
                        rd_tog   <= ~rd_tog;
                        sr_out   <= mirror(word_sel(sh_in[CMD_RSB_LO +: 3],
                                                    2'h0));
                     end
                     else
                        ps <= PS_WR;
                  end
                  else if (sh_in[7:0] == CMD_NULL)
                  begin
                     null_tog <= ~null_tog;
                     if (pf_s)
                     begin
                        ps       <= PS_CONV;
                        shifting <= 1'b1;
                        sr_out   <= mir_data;
                     end
                  end
               end
            default:
               if (word_done)
               begin
                  bitcnt <= 5'h0;
                  if (ps == PS_WR)
                  begin
                     wr_tog  <= ~wr_tog;
                     wr_sel  <= word_sel(sel, wcnt);
                     wr_word <= sh_in;
                  end
                  if (ps != PS_CONV && sel == REG_SETUP && wcnt != SETUP_LAST)
                  begin
                     wcnt   <= wcnt + 2'h1;
                     sr_out <= mirror(word_sel(sel, wcnt + 2'h1));
                  end
                  else
                  begin
                     ps       <= PS_CMD;
                     shifting <= 1'b0;
                  end
               end
         endcase
      end
   end

   // =====================================================
   // Crossing into the master clock domain
   acrc_sync2 #(.W(6)) u_sync_m
     (.clk_i (mclk_i),
      .rst_i (rst_i),
      .d_i   ({~cs_n_i, wr_tog, rd_tog, null_tog, shifting,
               sr_out[WORD_BITS-1]}),
      .q_o   (s_m));
   // Select lane is inverted so its reset value reads as deselected
   assign cs_s = ~s_m[5];

   // Toggle edges become one-cycle events
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_p   <= 1'b0;
         rd_p   <= 1'b0;
         null_p <= 1'b0;
      end
      else
      begin
         wr_p   <= s_m[4];
         rd_p   <= s_m[3];
         null_p <= s_m[2];
      end
   end
   assign wr_ev   = s_m[4] ^ wr_p;
   assign rd_ev   = s_m[3] ^ rd_p;
   assign null_ev = s_m[2] ^ null_p;

   // Mirrors freeze while selected so the link reads stable words
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mir_off  <= OFF_RST;
         mir_gain <= GAIN_RST;
         mir_cfg  <= CFG_RST;
         mir_data <= '0;
      end
      else if (cs_s)
      begin
         mir_off  <= offset_trim;
         mir_gain <= gain_slope;
         mir_cfg  <= cfg;
         mir_data <= conv_word_o;
      end
   end

   // =====================================================
   // Reset cycle, started by writing the reset bit high
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rst_busy <= 1'b0;
         rst_cnt  <= 10'h0;
      end
      else if (!rst_busy && wr_ev && wr_sel == REG_CFG && wr_word[CFG_RS])
      begin
         rst_busy <= 1'b1;
         rst_cnt  <= RESET_CYC - 10'h1;
      end
      else if (rst_busy)
      begin
         rst_cnt <= rst_cnt - 10'h1;
         if (rst_cnt == 10'h0)
            rst_busy <= 1'b0;
      end
   end
   assign rst_done = rst_busy && (rst_cnt == 10'h0);

   // Configuration; later assignments win, so a done set beats a clear
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         cfg <= CFG_RST;
      else if (rst_done)
         cfg <= CFG_RST | RS_MASK;
      else
      begin
         if (wr_ev && wr_sel == REG_CFG)
            cfg <= (wr_word & CFG_WMASK) | (cfg & ~CFG_WMASK);
         if (rd_ev && sel == REG_CFG)
            cfg[CFG_RV] <= 1'b0;
         if (rd_ev && sel != REG_CFG)
            cfg[CFG_DF] <= 1'b0;
         if (cal_done)
         begin
            cfg[CFG_DF]        <= 1'b1;
            cfg[CFG_CC_LO +: 3] <= 3'h0;
         end
      end
   end
   assign cc          = cfg[CFG_CC_LO +: 3];
   assign word_rate_o = cfg[CFG_WR_LO +: 3];

   // =====================================================
   // Conversion timing from the selected word rate
   always_comb
   begin
      case (cfg[CFG_WR_LO +: 3])
         3'h0:    owr_cyc = OWR_CYC_0;
         3'h1:    owr_cyc = OWR_CYC_1;
         3'h2:    owr_cyc = OWR_CYC_2;
         3'h3:    owr_cyc = OWR_CYC_3;
         3'h4:    owr_cyc = OWR_CYC_4;
         3'h5:    owr_cyc = OWR_CYC_5;
         3'h6:    owr_cyc = OWR_CYC_6;
         default: owr_cyc = OWR_CYC_7;
      endcase
   end

   // Counter restarts on a calibration start so a step is one whole conversion
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         conv_cnt <= OWR_CYC_0 - 15'h1;
      else if (cfg[CFG_RS] || cal_start || conv_cnt == 15'h0)
         conv_cnt <= owr_cyc - 15'h1;
      else
         conv_cnt <= conv_cnt - 15'h1;
   end
   assign conv_end = (conv_cnt == 15'h0) && !cfg[CFG_RS];

   // =====================================================
   // Calibration sequencer
   assign cal_start = (cst == CS_IDLE) && (cc[1:0] != 2'h0) && !cfg[CFG_RS];
   assign cal_done  = conv_end && ((cst == CS_OFF && !cc[1]) ||
                                   cst == CS_GAIN);

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         cst <= CS_IDLE;
      else if (cfg[CFG_RS])
         cst <= CS_IDLE;
      else
      begin
         case (cst)
            CS_IDLE:
               if (cal_start)
                  cst <= cc[0] ? CS_OFF : CS_GAIN;
            CS_OFF:
               if (conv_end)
                  cst <= cc[1] ? CS_GAIN : CS_IDLE;
            CS_GAIN:
               if (conv_end)
                  cst <= CS_IDLE;
            default:
               cst <= CS_IDLE;
         endcase
      end
   end

   // Gain result maps the measured full scale onto the code ceiling
   assign cal_diff  = 25'(signed'(sample_i)) - 25'(signed'(offset_trim));
   assign cal_quot  = (cal_diff > 25'sh0) ?
                      (46'(CAL_FS) << GAIN_FRAC) / 46'($unsigned(cal_diff)) :
                      46'(GAIN_MAX);
   assign gain_calc = (|cal_quot[45:24]) ? GAIN_MAX : cal_quot[23:0];

   // Offset and gain registers: reset, host writes, calibration results
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         offset_trim <= OFF_RST;
         gain_slope  <= GAIN_RST;
      end
      else if (rst_done)
      begin
         offset_trim <= OFF_RST;
         gain_slope  <= GAIN_RST;
      end
      else
      begin
         if (wr_ev && wr_sel == REG_OFF)
            offset_trim <= wr_word;
         if (wr_ev && wr_sel == REG_GAIN)
            gain_slope <= wr_word;
         if (conv_end && cst == CS_OFF)
            offset_trim <= sample_i;
         if (conv_end && cst == CS_GAIN)
            gain_slope <= gain_calc;
      end
   end

   // =====================================================
   // Output words
   acrc_correct u_correct
     (.sample_i (sample_i),
      .offset_i (offset_trim),
      .gain_i   (gain_slope),
      .word_o   (corr_word));

   // Calibration cycles produce no output word
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         conv_word_o   <= '0;
         conv_strobe_o <= 1'b0;
      end
      else
      begin
         conv_strobe_o <= conv_end && cst == CS_IDLE;
         if (conv_end && cst == CS_IDLE)
            conv_word_o <= corr_word;
      end
   end

   // Ready flag for port flag mode; a set beats a null clear
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         sdo_flag <= 1'b0;
      else if (rst_done)
         sdo_flag <= 1'b0;
      else if (cfg[CFG_PF] && (cal_done || (conv_end && cst == CS_IDLE)))
         sdo_flag <= 1'b1;
      else if (null_ev)
         sdo_flag <= 1'b0;
   end

   // Front end routing follows the active step
   always_comb
   begin
      if (cst == CS_IDLE)
         next_route = RT_NORMAL;
      else if (cc[2])
         next_route = RT_SYSTEM;
      else if (cst == CS_OFF)
         next_route = RT_SHORT;
      else
         next_route = RT_REF;
   end

   // Pins: data while shifting, else the inverted ready flag
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sdo_o       <= 1'b1;
         sdo_oe_n_o  <= 1'b1;
         cal_route_o <= RT_NORMAL;
      end
      else
      begin
         sdo_o       <= s_m[1] ? s_m[0] : ~sdo_flag;
         sdo_oe_n_o  <= cs_s;
         cal_route_o <= next_route;
      end
   end
endmodule

/* verification/acrc_host_model.sv */
// Host side model: framed transfers on the serial port.
// Assumes the caller starts each frame 1 ns after an mclk edge.
`timescale 1ns/1ps
module acrc_host_model
  (
   // Serial port, host driven
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      sdi_o,
   // Serial data from the device
   input  wire logic sdo_i
  );
   // Idle: clock stopped low, port deselected
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   // =====
   // One frame: command byte then a 24-bit word, 32 ns clock;
   // setup frames carry three words, each a copy of wd
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                       output logic [23:0] rd);
      int nb;
      nb = (cmd[7:5] == 3'h4 && cmd[3:1] == 3'h4) ? 72 : 24;
      rd = 24'h0;
      cs_n_o = 1'b0;
      #20;
      for (int i = nb + 7; i >= 0; i--)
      begin
         sdi_o = (i >= nb) ? cmd[i - nb] : wd[i % 24];
         #16 sclk_o = 1'b1;
         if (i < 24)
            rd[i] = sdo_i;
         #16 sclk_o = 1'b0;
      end
      // A released line must not keep its last bit
      #8 cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #40;
   endtask
endmodule

/* verification/acrc_top_asserts.sv */
// Port checker of the converter control block.
// Bound to acrc_top; sees its ports only.
`timescale 1ns/1ps
module acrc_top_asserts
  (
   // Clock and reset
   input wire logic                 mclk_i,
   input wire logic                 rst_i,
   // Observed ports
   input wire logic                 cs_n_i,
   input wire logic                 sdo_oe_n_o,
   input wire logic [1:0]           cal_route_o,
   input wire acrc_pkg::acrc_word_t conv_word_o,
   input wire logic                 conv_strobe_o
  );
   import acrc_pkg::*;
   int unsigned rt_cnt;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Length of a calibration; two steps at the slowest rate at most
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
         rt_cnt <= 0;
      else if (cal_route_o == 2'h0)
         rt_cnt <= 0;
      else
         rt_cnt <= rt_cnt + 1;
   // =====
   // Select edges seen through the three-stage enable path
   sequence cs_drop;
      $fell(cs_n_i) ##0 (!cs_n_i) [*4];
   endsequence
   sequence cs_lift;
      $rose(cs_n_i) ##0 cs_n_i [*4];
   endsequence
   a_oe_on_select: assert property (cs_drop |-> !sdo_oe_n_o)
      else $error("output not enabled after select");
   a_oe_not_early: assert property ($fell(cs_n_i) |-> sdo_oe_n_o [*2])
      else $error("output enabled too early");
   a_oe_off_late: assert property (cs_lift |-> sdo_oe_n_o)
      else $error("output still enabled after deselect");
   a_oe_hold_out: assert property ($rose(cs_n_i) |-> !sdo_oe_n_o [*2])
      else $error("output released too early");
   a_strobe_gap: assert property (
      conv_strobe_o |=> (!conv_strobe_o) [*8])
      else $error("conversion strobes too close");
   a_word_hold: assert property (
      !conv_strobe_o |-> $stable(conv_word_o))
      else $error("word changed without strobe");
   a_cal_bounded: assert property (rt_cnt <= 34896)
      else $error("calibration route held too long");
   a_route_step: assert property (
      $past(cal_route_o) != 2'h0 && cal_route_o != 2'h0 &&
      cal_route_o != $past(cal_route_o) |->
      $past(cal_route_o) == 2'h1 && cal_route_o == 2'h2)
      else $error("bad calibration step order");
endmodule
bind acrc_top acrc_top_asserts chk_u
  (.mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .sdo_oe_n_o(sdo_oe_n_o), .cal_route_o(cal_route_o),
   .conv_word_o(conv_word_o), .conv_strobe_o(conv_strobe_o));

/* verification/test_acrc_top.sv */
// Bench of the converter control: registers, conversion, calibration.
// Assumes the host model file and the bound checker.
`timescale 1ns/1ps
module test_acrc_top;
   import acrc_pkg::*;
   logic       mclk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       sclk, cs_n, sdi, sdo, strobe;
   logic [2:0] rate;
   logic [1:0] route;
   acrc_word_t sample = 24'h0;
   acrc_word_t word, r, w, v;
   int         err_total = 0;
   int         total_checks = 0;
   int         rcnt = 0;
   always #2 mclk_i = ~mclk_i;
   // Cycles with a calibration route active
   always @(posedge mclk_i)
      if (route != 2'h0)
         rcnt <= rcnt + 1;
   acrc_top dut_u
     (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(), .sample_i(sample),
      .word_rate_o(rate), .cal_route_o(route), .conv_word_o(word),
      .conv_strobe_o(strobe));
   acrc_host_model host_u
     (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
   // =====
   // Shared tasks
   task chk(input logic [23:0] s, input logic [23:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task rd(input acrc_sel_t s);
      host_u.xfer({4'h9, s, 1'b0}, 24'h0, r);
   endtask
   task wr(input acrc_sel_t s, input acrc_word_t d);
      host_u.xfer({4'h8, s, 1'b0}, d, w);
   endtask
   // Wait for n strobes; bounded so a silent design cannot hang
   task stb(input int n);
      for (int k = 0; k < n; k++)
      begin
         repeat (3000)
         begin
            @(posedge mclk_i);
            #1;
            if (strobe === 1'b1)
               break;
         end
         // A limit that runs out is a mismatch
         if (strobe !== 1'b1)
            err_total++;
      end
   endtask
   task idle;
      repeat (2000)
      begin
         @(posedge mclk_i);
         #1;
         if (route === 2'h0)
            break;
      end
      if (route !== 2'h0)
         err_total++;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // =====
   // Scenarios
   task t_reset;
      rd(REG_CFG);
      chk(r, 24'h000040);
      rd(REG_CFG);
      chk(r, 24'h000000);
      rd(REG_OFF);
      chk(r, 24'h000000);
      host_u.xfer(8'hff, 24'hffffff, r);
      rd(REG_GAIN);
      chk(r, 24'h400000);
      $display("reset test done");
   endtask
   task t_conv;
      wr(REG_CFG, 24'h008000);
      chk(24'(rate), 24'h4);
      sample = 24'h100000;
      stb(2);
      chk(word, 24'h100000);
      rd(REG_DATA);
      chk(r, 24'h100000);
      wr(REG_OFF, 24'h000100);
      wr(REG_GAIN, 24'h800000);
      stb(2);
      chk(word, 24'h1ffe00);
      wr(REG_OFF, 24'hffff00);
      stb(2);
      chk(word, 24'h200200);
      sample = 24'h7ffff0;
      stb(2);
      chk(word, 24'h7fffff);
      $display("conversion test done");
   endtask
   task t_cal;
      logic [2:0] cc;
      int         n;
      for (int i = 1; i < 8; i++)
      begin
         cc = 3'(i);
         if (cc == 3'h4)
            continue;
         n = (cc[1:0] == 2'h3) ? 648 : 324;
         sample = 24'h000200;
         rcnt = 0;
         wr(REG_CFG, {21'h001000, cc});
         chk(24'(route), cc[2] ? 24'h3 : (cc[0] ? 24'h1 : 24'h2));
         idle;
         chk(24'(rcnt >= n - 1 && rcnt <= n + 2), 24'h1);
         rd(REG_CFG);
         chk(r & 24'h00000f, 24'h000008);
      end
      rd(REG_CFG);
      chk(r & 24'h00000f, 24'h000008);
      rd(REG_OFF);
      chk(r, 24'h000200);
      rd(REG_CFG);
      chk(r & 24'h00000f, 24'h000000);
      rd(REG_GAIN);
      chk(r, 24'hffffff);
      wr(REG_OFF, 24'h000200);
      sample = 24'h400200;
      wr(REG_CFG, 24'h008022);
      idle;
      repeat (4) @(posedge mclk_i);
      #1;
      chk(24'(sdo), 24'h0);
      rd(REG_GAIN);
      chk(r, 24'h7fffff);
      stb(1);
      v = word;
      host_u.xfer(8'h00, 24'h0, r);
      chk(r, v);
      chk(24'(sdo), 24'h1);
      wr(REG_CFG, 24'h008000);
      $display("calibration test done");
   endtask
   task t_sreset;
      wr(REG_CFG, 24'h000080);
      repeat (1100) @(posedge mclk_i);
      #1;
      host_u.xfer(8'h00, 24'h0, r);
      rd(REG_CFG);
      chk(r, 24'h0000c0);
      rd(REG_CFG);
      chk(r, 24'h000080);
      rd(REG_OFF);
      chk(r, 24'h000000);
      rd(REG_GAIN);
      chk(r, 24'h400000);
      wr(REG_CFG, 24'h000000);
      rd(REG_CFG);
      chk(r, 24'h000000);
      $display("software reset test done");
   endtask
   // Setup command walks offset, gain and config in one frame
   task t_setup;
      wr(REG_SETUP, 24'h000010);
      rd(REG_SETUP);
      chk(r, 24'h000010);
      rd(REG_OFF);
      chk(r, 24'h000010);
      rd(REG_GAIN);
      chk(r, 24'h000010);
      $display("setup test done");
   endtask
   // Reset for 12 cycles, then the scenarios in turn
   initial
   begin
      repeat (12) @(posedge mclk_i);
      #1;
      rst_i = 1'b0;
      repeat (4) @(posedge mclk_i);
      #1;
      t_reset;
      t_conv;
      t_cal;
      t_sreset;
      t_setup;
      complete_run;
   end
   // Watchdog: about four times the expected run
   initial
   begin
      #300000;
      err_total++;
      complete_run;
   end
endmodule
